// >>> sgac_cfg.svh
// constants for the serial gigabit adapter control block
`ifndef SGAC_CFG_SVH
`define SGAC_CFG_SVH

// register byte offsets
`define SGAC_OFS_ID          8'h00
`define SGAC_OFS_RESET       8'h04
`define SGAC_OFS_CTRL        8'h10
`define SGAC_OFS_STATUS      8'h14
`define SGAC_OFS_LOC_ABIL    8'h18
`define SGAC_OFS_LOC_NP      8'h1c
`define SGAC_OFS_PART_ABIL   8'h20
`define SGAC_OFS_PART_NP     8'h24
`define SGAC_OFS_IRQ_STAT    8'h28
`define SGAC_OFS_IRQ_MASK    8'h2c
`define SGAC_OFS_DIAG_CLR    8'h40
`define SGAC_OFS_DIAG_SEL    8'h44
`define SGAC_OFS_DIAG_OUT    8'h48
`define SGAC_ADR_MASK        8'hfc

// reset register fields
`define SGAC_RST_GLOBAL      0
`define SGAC_RST_PATH        1

// control register fields
`define SGAC_CTL_AN_EN       0
`define SGAC_CTL_AN_RESTART  1
`define SGAC_CTL_FAST_TMR    2
`define SGAC_CTL_NP_READY    3
`define SGAC_CTL_LOOPBACK    4
`define SGAC_CTL_MASTER      5
`define SGAC_CTL_COMMA       6
`define SGAC_CTL_WIDTH       7

// status register fields
`define SGAC_ST_LINK         0
`define SGAC_ST_FAULT        1
`define SGAC_ST_DONE         2
`define SGAC_ST_PAGE         3
`define SGAC_ST_LOCK         4
`define SGAC_ST_SIGDET       5

// ability word fields
`define SGAC_AB_FULL_DUPLEX  12
`define SGAC_AB_SPEED_HI     11
`define SGAC_AB_SPEED_LO     10
`define SGAC_AB_FIBER_FD     5
`define SGAC_SPEED_GIG       2'h2

// interrupt status bits
`define SGAC_IRQ_PAGE        0
`define SGAC_IRQ_DONE        1
`define SGAC_IRQ_FAULT       2
`define SGAC_IRQ_LINK        3
`define SGAC_IRQ_WIDTH       4

// diagnostic select writable bits
`define SGAC_DIAG_SEL_MASK   7'h73

// reset values
`define SGAC_CTRL_RESET      7'h00
`define SGAC_WORD_RESET      16'h0000

// timing
`define SGAC_CLK_PERIOD_NS   100
`define SGAC_TMR_FIBER_NS    10000000
`define SGAC_TMR_SERIAL_NS   1600000
`define SGAC_TMR_FAST_NS     2000

`endif

// >>> sgac_pkg.sv
// types shared by the serial gigabit adapter control block
package sgac_pkg;

   // link timer state, one-hot
   typedef enum logic [1:0] {
      SGAC_TMR_IDLE = 2'b01,
      SGAC_TMR_RUN  = 2'b10
   } sgac_tmr_e;

   typedef logic [31:0] sgac_word_t;

endpackage : sgac_pkg

// >>> sgac_ctrl.sv
// control, status and register bank of the serial gigabit adapter
// ****************************************************************
// ****************************************************************
//
// Implementation choice: the Wishbone interface to the registers.
`timescale 1ns/1ns
`include "sgac_cfg.svh"

module sgac_ctrl
   import sgac_pkg::*;
#(
   parameter logic [31:0] ID_VALUE      = 32'h0001_0100, // arbitrary value
   parameter int unsigned FIBER_CYCLES  = `SGAC_TMR_FIBER_NS / `SGAC_CLK_PERIOD_NS,
   parameter int unsigned SERIAL_CYCLES = `SGAC_TMR_SERIAL_NS / `SGAC_CLK_PERIOD_NS
) (
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic        cyc_i,
   input  wire logic        stb_i,
   input  wire logic        we_i,
   input  wire logic [7:0]  adr_i,
   input  wire logic [3:0]  sel_i,
   input  wire logic [31:0] dat_i,
   output logic      [31:0] dat_o,
   output logic             ack_o,
   output logic             irq_o,
   input  wire logic        serial_mode_i,
   input  wire logic        lock_i,
   input  wire logic        optical_signal_present_i,
   input  wire logic        negotiation_done_i,
   input  wire logic        link_up_i,
   input  wire logic        page_rx_evt_i,
   input  wire logic [15:0] partner_word_i,
   input  wire logic [15:0] partner_np_i,
   input  wire logic        link_timer_start_i,
   output logic             link_timer_done_o,
   output logic             path_reset_hold_o,
   output logic             tx_force_comma_o,
   output logic             loopback_o,
   output logic             rx_clk_from_tx_o,
   output logic             negotiation_enable_o,
   output logic             negotiation_restart_o,
   output logic             next_page_ready_o,
   output logic [15:0]      local_ability_word_o,
   output logic [15:0]      local_next_page_word_o,
   output logic [1:0]       speed_o,
   output logic             full_duplex_o
);

   localparam int unsigned FAST_CYCLES_RAW = `SGAC_TMR_FAST_NS / `SGAC_CLK_PERIOD_NS;
   localparam int unsigned FAST_CYCLES     = (FAST_CYCLES_RAW < 1) ? 1 : FAST_CYCLES_RAW;
   localparam int unsigned MAX_CYCLES      = (FIBER_CYCLES > SERIAL_CYCLES) ? FIBER_CYCLES : SERIAL_CYCLES;
   localparam int unsigned CW              = $clog2(MAX_CYCLES + 1);

   typedef struct packed {
      logic                       ack;
      logic [31:0]                rdata;
      logic                       glob_rst;
      logic                       path_rst;
      logic [`SGAC_CTL_WIDTH-1:0] ctrl;
      logic [15:0]                loc_abil;
      logic [15:0]                loc_np;
      logic [15:0]                part_abil;
      logic [15:0]                part_np;
      logic                       page_pend;
      logic                       page_flag;
      logic                       done_q;
      logic                       link_q;
      logic                       fault_q;
      logic                       restart;
      logic [`SGAC_IRQ_WIDTH-1:0] irq_st;
      logic [`SGAC_IRQ_WIDTH-1:0] irq_mask;
      logic [6:0]                 diag_sel;
      sgac_tmr_e                  tmr_state;
      logic [CW-1:0]              tmr_cnt;
      logic                       tmr_done;
   } sgac_state_s;

   sgac_state_s s;
   sgac_state_s next_s;

   // ****************************************************************
   // helpers
   // ****************************************************************
   function automatic logic [31:0] merge_bytes(input logic [31:0] old_v,
                                               input logic [31:0] new_v,
                                               input logic [3:0]  sel);
      logic [31:0] res;
      res = old_v;
      for (int b = 0; b < 4; b++) begin
         if (sel[b]) begin
            res[b*8 +: 8] = new_v[b*8 +: 8];
         end
      end
      return res;
   endfunction : merge_bytes

   function automatic logic [CW-1:0] timer_load(input logic fast, input logic serial);
      if (fast) begin
         return CW'(FAST_CYCLES - 1);
      end
      else if (serial) begin
         return CW'(SERIAL_CYCLES - 1);
      end
      return CW'(FIBER_CYCLES - 1);
   endfunction : timer_load

   function automatic logic [1:0] speed_bits(input logic [15:0] word);
      return {word[`SGAC_AB_SPEED_HI], word[`SGAC_AB_SPEED_LO]};
   endfunction : speed_bits

   function automatic logic [7:0] word_addr(input logic [7:0] adr);
      return adr & `SGAC_ADR_MASK;
   endfunction : word_addr

   // ****************************************************************
   // derived values
   // ****************************************************************
   logic [15:0] speed_word;
   logic        fault_now;
   logic        req;
   logic        wr;
   logic [31:0] wmask;
   logic [31:0] status_word;

   assign req  = cyc_i & stb_i;
   assign wr   = req & we_i & s.ack;
   assign wmask = merge_bytes(32'h0000_0000, dat_i, sel_i);

   assign speed_word = s.ctrl[`SGAC_CTL_MASTER] ? s.loc_abil : s.part_abil;

   always_comb begin
      if (serial_mode_i) begin
         fault_now = ~speed_word[`SGAC_AB_FULL_DUPLEX] &
                     (speed_bits(speed_word) == `SGAC_SPEED_GIG);
      end
      else begin
         fault_now = ~(s.loc_abil[`SGAC_AB_FIBER_FD] & s.part_abil[`SGAC_AB_FIBER_FD]);
      end
   end

   // ****************************************************************
   // status word
   // ****************************************************************
   always_comb begin
      status_word = 32'h0000_0000;
      status_word[`SGAC_ST_SIGDET] = optical_signal_present_i;
      status_word[`SGAC_ST_LOCK]   = lock_i;
      status_word[`SGAC_ST_PAGE]   = lock_i & s.page_flag;
      status_word[`SGAC_ST_DONE]   = lock_i & s.done_q;
      status_word[`SGAC_ST_FAULT]  = lock_i & s.done_q & s.fault_q;
      status_word[`SGAC_ST_LINK]   = lock_i & s.link_q;
   end

   // ****************************************************************
   // next state
   // ****************************************************************
   always_comb begin
      logic [31:0]                m;
      logic [`SGAC_IRQ_WIDTH-1:0] evt;
      logic [`SGAC_IRQ_WIDTH-1:0] clr;
      m      = 32'h0000_0000;
      evt    = '0;
      clr    = '0;
      next_s = s;

      // ****************************************************************
      // bus answer, one cycle after the request
      // ****************************************************************
      next_s.ack = req & ~s.ack;
      if (req & ~s.ack) begin
         case (word_addr(adr_i))
            `SGAC_OFS_ID:        next_s.rdata = ID_VALUE;
            `SGAC_OFS_RESET:     next_s.rdata = {30'h0, s.path_rst, 1'b0};
            `SGAC_OFS_CTRL:      next_s.rdata = {25'h0, s.ctrl};
            `SGAC_OFS_STATUS:    next_s.rdata = status_word;
            `SGAC_OFS_LOC_ABIL:  next_s.rdata = {16'h0, s.loc_abil};
            `SGAC_OFS_LOC_NP:    next_s.rdata = {16'h0, s.loc_np};
            `SGAC_OFS_PART_ABIL: next_s.rdata = {16'h0, s.done_q ? s.part_abil : `SGAC_WORD_RESET};
            `SGAC_OFS_PART_NP:   next_s.rdata = {16'h0, s.part_np};
            `SGAC_OFS_IRQ_STAT:  next_s.rdata = {28'h0, s.irq_st};
            `SGAC_OFS_IRQ_MASK:  next_s.rdata = {28'h0, s.irq_mask};
            `SGAC_OFS_DIAG_SEL:  next_s.rdata = {25'h0, s.diag_sel};
            default:             next_s.rdata = 32'h0000_0000;
         endcase
      end

      // ****************************************************************
      // register writes on the acknowledged edge
      // ****************************************************************
      if (wr) begin
         case (word_addr(adr_i))
            `SGAC_OFS_RESET: begin
               m = merge_bytes({30'h0, s.path_rst, 1'b0}, dat_i, sel_i);
               next_s.path_rst = m[`SGAC_RST_PATH];
               next_s.glob_rst = m[`SGAC_RST_GLOBAL];
            end
            `SGAC_OFS_CTRL: begin
               m = merge_bytes({25'h0, s.ctrl}, dat_i, sel_i);
               next_s.ctrl = m[`SGAC_CTL_WIDTH-1:0];
               if (wmask[`SGAC_CTL_NP_READY]) begin
                  next_s.page_flag = 1'b0;
               end
            end
            `SGAC_OFS_LOC_ABIL: begin
               m = merge_bytes({16'h0, s.loc_abil}, dat_i, sel_i);
               next_s.loc_abil = m[15:0];
            end
            `SGAC_OFS_LOC_NP: begin
               m = merge_bytes({16'h0, s.loc_np}, dat_i, sel_i);
               next_s.loc_np = m[15:0];
            end
            `SGAC_OFS_IRQ_STAT: clr = wmask[`SGAC_IRQ_WIDTH-1:0];
            `SGAC_OFS_IRQ_MASK: begin
               m = merge_bytes({28'h0, s.irq_mask}, dat_i, sel_i);
               next_s.irq_mask = m[`SGAC_IRQ_WIDTH-1:0];
            end
            `SGAC_OFS_DIAG_SEL: begin
               m = merge_bytes({25'h0, s.diag_sel}, dat_i, sel_i);
               next_s.diag_sel = m[6:0] & `SGAC_DIAG_SEL_MASK;
            end
            default: begin
            end
         endcase
      end

      // ****************************************************************
      // restart pulse after a one then a zero
      // ****************************************************************
      next_s.restart = s.ctrl[`SGAC_CTL_AN_RESTART] & ~next_s.ctrl[`SGAC_CTL_AN_RESTART]
                       & s.ctrl[`SGAC_CTL_AN_EN];

      // ****************************************************************
      // next-page exchange, fiber only
      // ****************************************************************
      next_s.page_pend = page_rx_evt_i & ~serial_mode_i;
      if (page_rx_evt_i & ~serial_mode_i) begin
         next_s.ctrl[`SGAC_CTL_NP_READY] = 1'b0;
         next_s.part_np = partner_np_i;
      end
      if (s.page_pend) begin
         next_s.page_flag = 1'b1;
      end

      // ****************************************************************
      // negotiation results
      // ****************************************************************
      next_s.done_q  = negotiation_done_i & s.ctrl[`SGAC_CTL_AN_EN];
      next_s.link_q  = link_up_i;
      next_s.fault_q = fault_now;
      if (negotiation_done_i & ~s.done_q) begin
         next_s.part_abil = partner_word_i;
      end

      // ****************************************************************
      // link timer
      // ****************************************************************
      next_s.tmr_done = 1'b0;
      case (s.tmr_state)
         SGAC_TMR_IDLE: begin
            if (link_timer_start_i) begin
               next_s.tmr_cnt   = timer_load(s.ctrl[`SGAC_CTL_FAST_TMR], serial_mode_i);
               next_s.tmr_state = SGAC_TMR_RUN;
            end
         end
         SGAC_TMR_RUN: begin
            if (link_timer_start_i) begin
               next_s.tmr_cnt = timer_load(s.ctrl[`SGAC_CTL_FAST_TMR], serial_mode_i);
            end
            else if (s.tmr_cnt == '0) begin
               next_s.tmr_done  = 1'b1;
               next_s.tmr_state = SGAC_TMR_IDLE;
            end
            else begin
               next_s.tmr_cnt = s.tmr_cnt - CW'(1);
            end
         end
         default: next_s.tmr_state = SGAC_TMR_IDLE;
      endcase

      // ****************************************************************
      // interrupt events, set wins over clear
      // ****************************************************************
      evt[`SGAC_IRQ_PAGE]  = s.page_pend;
      evt[`SGAC_IRQ_DONE]  = next_s.done_q & ~s.done_q;
      evt[`SGAC_IRQ_FAULT] = s.done_q & fault_now & ~s.fault_q;
      evt[`SGAC_IRQ_LINK]  = link_up_i ^ s.link_q;
      next_s.irq_st = (s.irq_st & ~clr) | evt;
   end

   // ****************************************************************
   // state register
   // ****************************************************************
   always_ff @(posedge clk_i) begin
      if (rst_i | s.glob_rst) begin
         s           <= '0;
         s.ctrl      <= `SGAC_CTRL_RESET;
         s.tmr_state <= SGAC_TMR_IDLE;
      end
      else begin
         s <= next_s;
      end
   end

   // ****************************************************************
   // outputs
   // ****************************************************************
   assign dat_o                  = s.rdata;
   assign ack_o                  = s.ack;
   assign irq_o                  = |(s.irq_st & s.irq_mask);
   assign link_timer_done_o      = s.tmr_done;
   assign path_reset_hold_o      = s.path_rst | s.glob_rst;
   assign tx_force_comma_o       = s.ctrl[`SGAC_CTL_COMMA];
   assign loopback_o             = s.ctrl[`SGAC_CTL_LOOPBACK];
   assign rx_clk_from_tx_o       = s.ctrl[`SGAC_CTL_LOOPBACK];
   assign negotiation_enable_o   = s.ctrl[`SGAC_CTL_AN_EN];
   assign negotiation_restart_o  = s.restart;
   assign next_page_ready_o      = s.ctrl[`SGAC_CTL_NP_READY] & ~serial_mode_i;
   assign local_ability_word_o   = s.loc_abil;
   assign local_next_page_word_o = s.loc_np;
   assign speed_o                = speed_bits(speed_word);
   assign full_duplex_o          = speed_word[`SGAC_AB_FULL_DUPLEX];

endmodule : sgac_ctrl

// >>> sgac_ctrl_props.sv
// concurrent checks on the ports of the adapter control block
`timescale 1ns/1ns
`include "sgac_cfg.svh"
module sgac_ctrl_props
   import sgac_pkg::*;
#(
   parameter int unsigned FIBER_CYCLES  = 100000,
   parameter int unsigned SERIAL_CYCLES = 16000
) (
   input wire logic        clk_i,
   input wire logic        rst_i,
   input wire logic        cyc_i,
   input wire logic        stb_i,
   input wire logic        we_i,
   input wire logic [7:0]  adr_i,
   input wire logic [3:0]  sel_i,
   input wire logic [31:0] dat_i,
   input wire logic        ack_o,
   input wire logic        serial_mode_i,
   input wire logic        page_rx_evt_i,
   input wire logic        link_timer_start_i,
   input wire logic        link_timer_done_o,
   input wire logic        path_reset_hold_o,
   input wire logic        tx_force_comma_o,
   input wire logic        loopback_o,
   input wire logic        rx_clk_from_tx_o,
   input wire logic        negotiation_enable_o,
   input wire logic        negotiation_restart_o,
   input wire logic        next_page_ready_o
);
   // ****************************
   // bus, control, next page, reset and link timer checks
   // ****************************
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   logic wr_ack;
   logic rst_wr;
   assign wr_ack = cyc_i && stb_i && we_i && ack_o;
   assign rst_wr = wr_ack && {adr_i[7:2], 2'b00} == `SGAC_OFS_RESET && sel_i[0];
   chk_ack_answer: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
      else $error("no ack one cycle after request");
   chk_ack_pulse: assert property (ack_o |=> !ack_o) else $error("ack held too long");
   chk_ctrl_write: assert property (wr_ack && {adr_i[7:2], 2'b00} == `SGAC_OFS_CTRL && sel_i[0] |=>
      tx_force_comma_o == $past(dat_i[6]) && loopback_o == $past(dat_i[4])
      && negotiation_enable_o == $past(dat_i[0])) else $error("control outputs differ from write");
   chk_loop_clock: assert property (loopback_o == rx_clk_from_tx_o) else $error("rx clock select wrong");
   chk_np_serial: assert property (serial_mode_i |-> !next_page_ready_o) else $error("page ready in serial");
   chk_np_clear: assert property (page_rx_evt_i && !serial_mode_i |=> !next_page_ready_o)
      else $error("page ready not cleared");
   chk_restart_pulse: assert property (negotiation_restart_o |-> negotiation_enable_o ##1 !negotiation_restart_o)
      else $error("bad restart pulse");
   chk_path_hold: assert property (rst_wr && dat_i[1] |=> path_reset_hold_o) else $error("path not held");
   chk_global_reset: assert property (rst_wr && dat_i[0] |=> path_reset_hold_o ##1
      !(negotiation_enable_o || tx_force_comma_o || loopback_o)) else $error("soft reset missed");
   chk_timer_min: assert property (link_timer_start_i |=> !link_timer_done_o [*8])
      else $error("timer expired too early");
   cover property (wr_ack);
   cover property (negotiation_restart_o);
   cover property (link_timer_done_o);
   cover property (page_rx_evt_i);
endmodule : sgac_ctrl_props
bind sgac_ctrl sgac_ctrl_props #(.FIBER_CYCLES(FIBER_CYCLES), .SERIAL_CYCLES(SERIAL_CYCLES)) u_props (.*);

// >>> sgac_engine_model.sv
// far-side negotiation engine and link partner model
`timescale 1ns/1ns
module sgac_engine_model
   import sgac_pkg::*;
#(
   parameter logic [15:0] NP_WORD = 16'h2b6d
) (
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic        serial_mode_i,
   input  wire logic        phy_side_i,
   input  wire logic [15:0] fiber_word_i,
   input  wire logic        negotiation_enable_i,
   input  wire logic        negotiation_restart_i,
   input  wire logic        next_page_ready_i,
   input  wire logic        link_timer_done_i,
   output logic             link_timer_start_o,
   output logic             done_o,
   output logic             page_rx_evt_o,
   output logic [15:0]      partner_word_o,
   output logic [15:0]      partner_np_o
);
   // ****************************
   // partner words and handshakes
   // ****************************
   logic       en_q;
   logic [1:0] pg;
   assign partner_word_o = !serial_mode_i ? fiber_word_i : phy_side_i ? 16'h4001 : 16'hc801;
   assign partner_np_o   = page_rx_evt_o ? NP_WORD : ~NP_WORD;
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         {en_q, link_timer_start_o, done_o, page_rx_evt_o, pg} <= '0;
      end else begin
         en_q <= negotiation_enable_i;
         link_timer_start_o <= (negotiation_enable_i && !en_q) || negotiation_restart_i;
         if (link_timer_start_o) begin
            done_o <= 1'b0;
         end else if (link_timer_done_i && negotiation_enable_i) begin
            done_o <= 1'b1;
         end
         page_rx_evt_o <= (pg == 2'd2);
         if (!(next_page_ready_i && done_o && !serial_mode_i)) begin
            pg <= 2'd0;
         end else if (pg != 2'd3) begin
            pg <= pg + 2'd1;
         end
      end
   end
endmodule : sgac_engine_model

// >>> sgac_ctrl_tb_top.sv
// self-checking bench for the adapter control block
`timescale 1ns/1ns
`include "sgac_cfg.svh"
`define CHK(g, x) begin total_checks++; if ((g) !== (x)) begin num_errors++; \
   $display("BAD t=%0t got=%h exp=%h", $time, g, x); end end
module sgac_ctrl_tb_top
   import sgac_pkg::*;
;
   localparam int unsigned FIB  = 50;
   localparam int unsigned SER  = 30;
   localparam logic [31:0] ID_W = 32'h0000_3c5a; // arbitrary value
   localparam logic [15:0] NP   = 16'h2b6d;
   logic clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, irq_o, serial_mode_i, lock_i, optical_signal_present_i, phy;
   logic negotiation_done_i, link_up_i, page_rx_evt_i, link_timer_start_i, link_timer_done_o;
   logic path_reset_hold_o, tx_force_comma_o, loopback_o, rx_clk_from_tx_o, negotiation_enable_o;
   logic negotiation_restart_o, next_page_ready_o, full_duplex_o;
   logic [1:0]  speed_o;
   logic [3:0]  sel_i, s;
   logic [7:0]  adr_i, a;
   logic [31:0] dat_i, dat_o, q, d;
   logic [15:0] partner_word_i, partner_np_i, local_ability_word_o, local_next_page_word_o, fw, e;
   logic [15:0] mir [2] = '{16'h0, 16'h0};
   int          num_errors = 0, total_checks = 0, tcnt = 0, tgap = 0, nrst = 0, n0, i, k, g [3];
   assign link_up_i = negotiation_done_i;
   sgac_ctrl #(.ID_VALUE(ID_W), .FIBER_CYCLES(FIB), .SERIAL_CYCLES(SER)) uut (.*);
   sgac_engine_model #(.NP_WORD(NP)) partner (.clk_i, .rst_i, .serial_mode_i, .phy_side_i(phy),
      .fiber_word_i(fw), .negotiation_enable_i(negotiation_enable_o), .negotiation_restart_i(negotiation_restart_o),
      .next_page_ready_i(next_page_ready_o), .link_timer_done_i(link_timer_done_o),
      .link_timer_start_o(link_timer_start_i), .done_o(negotiation_done_i), .page_rx_evt_o(page_rx_evt_i),
      .partner_word_o(partner_word_i), .partner_np_o(partner_np_i));
   initial begin
      clk_i = 1'b0;
      forever #50 clk_i = ~clk_i;
   end
   always @(posedge clk_i) begin
      tcnt <= link_timer_start_i ? 0 : tcnt + 1;
      if (link_timer_done_o === 1'b1) tgap <= tcnt;
      if (negotiation_restart_o === 1'b1) nrst <= nrst + 1;
   end
   task complete_run;
      $display("checks %0d errors %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : complete_run
   task automatic wb(input logic w, input logic [7:0] ad, input logic [31:0] dt, input logic [3:0] sl);
      int n;
      n = 0;
      @(posedge clk_i);
      {cyc_i, stb_i, we_i, adr_i, dat_i, sel_i} <= {2'b11, w, ad, dt, sl};
      do begin @(posedge clk_i); n++; end while (ack_o !== 1'b1 && n < 20);
      q = dat_o;
      {cyc_i, stb_i, we_i} <= 3'b000;
      if (n >= 20) begin num_errors++; complete_run(); end
      @(negedge clk_i);
   endtask : wb
   task automatic chkrd(input logic [7:0] ad, input logic [31:0] x);
      wb(1'b0, ad, 32'h0, 4'hf);
      `CHK(q, x)
   endtask : chkrd
   task automatic wt(ref logic sg);
      int n;
      n = 0;
      while (sg !== 1'b1 && n < 400) begin @(posedge clk_i); n++; end
      if (n >= 400) begin num_errors++; complete_run(); end
   endtask : wt
   // ****************************
   // main sequence
   // ****************************
   initial begin
      {cyc_i, stb_i, we_i, serial_mode_i, lock_i, optical_signal_present_i, phy, rst_i} = 8'h01;
      {adr_i, sel_i, dat_i, fw} = '0;
      void'($urandom(32'h7c76));
      repeat (16) @(posedge clk_i);
      rst_i <= 1'b0;
      foreach (g[j]) wb(1'b1, 8'h14 + 8'(j) * 8'h0e, '1, 4'hf);
      chkrd(8'h00, ID_W);
      foreach (g[j]) chkrd(8'h14 + 8'(j) * 8'h0e, 32'h0);
      chkrd(8'h10, 32'h0);
      $display("test reset values done");
      repeat (6) begin
         i = $urandom_range(1);
         a = i ? 8'h1c : 8'h18;
         d = $urandom;
         s = 4'($urandom);
         wb(1'b1, a, d, s);
         mir[i] = {s[1] ? d[15:8] : mir[i][15:8], s[0] ? d[7:0] : mir[i][7:0]};
         chkrd(a, {16'h0, mir[i]});
      end
      `CHK({local_ability_word_o, local_next_page_word_o}, {mir[0], mir[1]})
      $display("test local words done");
      repeat (6) begin
         d = $urandom & 32'hffff_fff4;
         @(posedge clk_i) {lock_i, optical_signal_present_i} <= 2'($urandom);
         wb(1'b1, 8'h10, d, 4'hf);
         chkrd(8'h10, d & 32'h74);
         `CHK({tx_force_comma_o, loopback_o, rx_clk_from_tx_o}, {d[6], d[4], d[4]})
         `CHK(speed_o, d[5] ? mir[0][11:10] : 2'b00)
         chkrd(8'h14, {26'h0, optical_signal_present_i, lock_i, 4'h0});
      end
      $display("test control done");
      for (k = 0; k < 3; k++) begin
         wb(1'b1, 8'h10, 32'h0, 4'hf);
         @(posedge clk_i) serial_mode_i <= (k == 1);
         wb(1'b1, 8'h10, k == 0 ? 32'h5 : 32'h1, 4'hf);
         wt(link_timer_done_o);
         @(negedge clk_i) g[k] = tgap;
      end
      `CHK(g[1] - g[0], int'(SER) - 20)
      `CHK(g[2] - g[0], int'(FIB) - 20)
      $display("test link timer done");
      wb(1'b1, 8'h18, 32'h0, 4'hf);
      for (k = 0; k < 3; k++) begin
         wb(1'b1, 8'h10, 32'h0, 4'hf);
         @(posedge clk_i) {serial_mode_i, phy, lock_i, fw} <= {k != 0, k == 2, 1'b1, 16'($urandom) | 16'h0020};
         wb(1'b1, 8'h10, 32'h1, 4'hf);
         repeat (3) @(posedge clk_i);
         wt(negotiation_done_i);
         e = k == 0 ? fw : k == 1 ? 16'hc801 : 16'h4001;
         chkrd(8'h20, {16'h0, e});
         chkrd(8'h14, {26'h0, optical_signal_present_i, 1'b1, 1'b0, 1'b1, k != 2, 1'b1});
         `CHK({speed_o, full_duplex_o}, {e[11:10], e[12]})
      end
      wb(1'b1, 8'h18, 32'h1400, 4'hf);
      wb(1'b1, 8'h10, 32'h21, 4'hf);
      `CHK({speed_o, full_duplex_o}, 3'b011)
      wb(1'b1, 8'h10, 32'h20, 4'hf);
      chkrd(8'h14, {26'h0, optical_signal_present_i, 5'b10001});
      `CHK(q[2], 1'b0)
      $display("test negotiation done");
      n0 = nrst;
      foreach (g[j]) wb(1'b1, 8'h10, 32'h2 >> (j % 2), 4'hf);
      foreach (g[j]) wb(1'b1, 8'h10, 32'h1 << (j % 2) | 32'h1, 4'hf);
      repeat (2) @(posedge clk_i);
      `CHK(nrst - n0, 1)
      $display("test restart done");
      @(posedge clk_i) serial_mode_i <= 1'b0;
      wb(1'b1, 8'h2c, 32'h1, 4'hf);
      wb(1'b1, 8'h10, 32'h9, 4'hf);
      wt(irq_o);
      chkrd(8'h10, 32'h1);
      chkrd(8'h24, {16'h0, NP});
      chkrd(8'h14, {26'h0, optical_signal_present_i, 5'b11111});
      `CHK(q[3], 1'b1)
      wb(1'b1, 8'h28, 32'h1, 4'hf);
      `CHK(irq_o, 1'b0)
      $display("test next page done");
      wb(1'b1, 8'h04, 32'h2, 4'hf);
      `CHK(path_reset_hold_o, 1'b1)
      chkrd(8'h04, 32'h2);
      wb(1'b1, 8'h04, 32'h0, 4'hf);
      `CHK(path_reset_hold_o, 1'b0)
      wb(1'b1, 8'h04, 32'h1, 4'hf);
      foreach (g[j]) chkrd(8'h04 + 8'(j) * 8'h0a, 32'h0);
      $display("test soft resets done");
      complete_run();
   end
endmodule : sgac_ctrl_tb_top
